/* shared/elts_pkg.sv */
// Purpose: Shared constants and types for the edit lockout and trace block
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   Offsets, fields, reset values and timing counts live here
package elts_pkg;

  // Register byte offsets
  localparam logic [7:0] ELTS_OFF_EDIT_CTRL  = 8'h00; // Validator and disable bit
  localparam logic [7:0] ELTS_OFF_EDIT_STAT  = 8'h04; // Wait, processing, error flags
  localparam logic [7:0] ELTS_OFF_OUT_CTRL   = 8'h08; // Output-off bit
  localparam logic [7:0] ELTS_OFF_TR_CFG     = 8'h0c; // Mode, period, word count
  localparam logic [7:0] ELTS_OFF_TR_DELAY   = 8'h10; // Signed delay
  localparam logic [7:0] ELTS_OFF_TR_CTRL    = 8'h14; // Sampling start, trigger
  localparam logic [7:0] ELTS_OFF_TR_STAT    = 8'h18; // Trace state, pointer
  localparam logic [7:0] ELTS_OFF_TR_RADDR   = 8'h1c; // Trace memory read index
  localparam logic [7:0] ELTS_OFF_TR_RDATA   = 8'h20; // Trace memory read data

  // Field positions
  localparam int ELTS_VAL_LSB      = 0;  // Validator bits 7..0
  localparam int ELTS_DIS_BIT      = 9;  // Edit-disable bit
  localparam int ELTS_WAIT_BIT     = 10; // Edit-wait flag
  localparam int ELTS_PROC_BIT     = 11; // Edit-processing flag
  localparam int ELTS_ERR_BIT      = 0;  // Discarded-request error, W1C
  localparam int ELTS_OUTOFF_BIT   = 15; // Output-off bit
  localparam int ELTS_TR_START_BIT = 15; // Sampling-start bit
  localparam int ELTS_TR_TRIG_BIT  = 14; // Trigger-start bit

  // Values
  localparam logic [7:0] ELTS_VALID_KEY = 8'h5a; // Qualifying validator value
  localparam logic [7:0] ELTS_VAL_RST   = 8'h00;
  localparam int         ELTS_MEM_WORDS = 4000;  // Trace memory capacity
  localparam int         ELTS_MAX_BITS  = 31;
  localparam int         ELTS_MAX_WORDS = 6;

  // Timing: period step is 10 ms
  localparam int  ELTS_STEP_MS       = 10;
  localparam int  ELTS_CLK_MHZ       = 200;
  localparam int  ELTS_STEP_CYC      = ELTS_STEP_MS * 1000 * ELTS_CLK_MHZ;

  // Sampling sources
  typedef enum logic [1:0] {
    ELTS_SRC_PERIOD = 2'b00,
    ELTS_SRC_CYCLE  = 2'b01,
    ELTS_SRC_INSTR  = 2'b10
  } elts_src_t;

  // Trace sampler states
  typedef enum logic [1:0] {
    ELTS_TR_IDLE = 2'b00,
    ELTS_TR_PRE  = 2'b01,
    ELTS_TR_POST = 2'b10,
    ELTS_TR_DONE = 2'b11
  } elts_trst_t;

  // Edit lockout states
  typedef enum logic [1:0] {
    ELTS_ED_IDLE = 2'b00,
    ELTS_ED_WAIT = 2'b01,
    ELTS_ED_RUN  = 2'b10
  } elts_edst_t;

  // Edit request group from the programming device
  typedef struct packed {
    logic       req;   // One-cycle request
    logic       done;  // Edit operation finished
  } elts_edit_t;

endpackage : elts_pkg

/* verilog/elts_core.sv */
// Purpose: Online edit lockout, output-off control and data trace sampler
// Assumes: One clock; scan-cycle events arrive as one-cycle pulses on mclk_i
// Notes:   Registers over APB; trace memory is a local array
`timescale 1ns/1ps
`default_nettype none
module elts_core
  import elts_pkg::*;
#(
  parameter int STEP_CYC = ELTS_STEP_CYC, // Cycles per 10 ms step
  parameter int OUT_W    = 32            // Width of gated output image
) (
  input  wire logic                      mclk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [7:0]                paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire elts_pkg::elts_edit_t      edit_i,
  output logic                           edit_go_o,
  output logic                           edit_err_o,
  input  wire logic                      outoff_nv_i,
  input  wire logic [OUT_W-1:0]          out_img_i,
  output logic      [OUT_W-1:0]          out_pins_o,
  output logic                           output_inhibit_indicator_o,
  input  wire logic                      scan_end_i,
  input  wire logic                      trace_sample_instruction_i,
  input  wire logic [30:0]               tr_bits_i,
  input  wire logic [95:0]               tr_words_i
);

  localparam int AW = 12; // Trace memory index width
  localparam int CW = AW + 1; // Post-trigger count, holds depth plus delay

  // Sample row width: 31 bits plus 6 words of 16
  localparam int ROW_W = ELTS_MAX_BITS + 16 * ELTS_MAX_WORDS;

  // Last ring index (depth in samples minus one) for a given word count (one word for the bits)
  function automatic logic [AW-1:0] depth_of(input logic [2:0] nw);
    depth_of = AW'(ELTS_MEM_WORDS / (32'(nw) + 1) - 1);
  endfunction : depth_of

  // Register file
  logic [7:0]       val_r;         // Validator
  logic             dis_r;         // Edit-disable bit
  logic             err_r;         // Discarded request flag
  logic             outoff_r;      // Output-off bit
  logic [1:0]       src_r;         // Sampling source
  logic [7:0]       per_r;         // Period in 10 ms steps
  logic [2:0]       nw_r;          // Words per sample
  logic [12:0]      dly_r;         // Signed delay
  logic             start_r;       // Sampling-start bit
  logic             trig_r;        // Trigger-start bit
  logic [AW-1:0]    rdidx_r;       // Read index
  logic             init_r;        // First cycle after reset

  // Edit lockout state
  elts_edst_t       ed_r;
  logic             pend_r;        // Request held across a running edit
  logic             lock;          // Valid disable
  logic             refuse;        // Request to be discarded

  // Trace state
  elts_trst_t       tr_r;
  logic [AW-1:0]    wp_r;          // Write pointer
  logic [CW-1:0]    cnt_r;         // Samples remaining after trigger
  logic [31:0]      tick_r;        // Step timer
  logic [7:0]       stepc_r;       // Step count within period
  logic [ROW_W-1:0] mem [0:ELTS_MEM_WORDS-1];
  logic [ROW_W-1:0] rd_r;
  logic             strobe;        // Sample strobe from the selected source
  logic             wr_acc, rd_acc;
  logic [31:0]      rdata;
  logic             hit;

  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_acc = psel_i & penable_i & ~pwrite_i;

  // Disable counts only with the key present
  assign lock = dis_r & (val_r == ELTS_VALID_KEY);

  // A request finding one already held is dropped, not queued deeper
  assign refuse = edit_i.req && (ed_r == ELTS_ED_WAIT ||
                                 (ed_r == ELTS_ED_RUN && pend_r));

  // Edit control writes; writes land on the access edge
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      val_r <= ELTS_VAL_RST;
      dis_r <= 1'b0;
    end else if (wr_acc && paddr_i == ELTS_OFF_EDIT_CTRL) begin
      val_r <= pwdata_i[ELTS_VAL_LSB +: 8];
      dis_r <= pwdata_i[ELTS_DIS_BIT];
    end
  end

  // Output-off bit: after reset reload from the nonvolatile copy, since
  // the sync reset branch loads only a constant the strap is caught here
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      init_r <= 1'b1;
    end else begin
      init_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      outoff_r <= 1'b0;
    end else if (init_r) begin
      outoff_r <= outoff_nv_i;
    end else if (wr_acc && paddr_i == ELTS_OFF_OUT_CTRL) begin
      outoff_r <= pwdata_i[ELTS_OUTOFF_BIT];
    end
  end

  // Gated outputs and indicator
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      out_pins_o                 <= '0;
      output_inhibit_indicator_o <= 1'b0;
    end else begin
      out_pins_o                 <= outoff_r ? '0 : out_img_i;
      output_inhibit_indicator_o <= outoff_r;
    end
  end

  // Edit lockout sequencer
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ed_r      <= ELTS_ED_IDLE;
      pend_r    <= 1'b0;
      edit_go_o <= 1'b0;
    end else begin
      edit_go_o <= 1'b0;
      case (ed_r)
        ELTS_ED_IDLE: begin
          if (edit_i.req || pend_r) begin
            if (lock) begin
              ed_r   <= ELTS_ED_WAIT;
              pend_r <= 1'b0;
            end else begin
              ed_r      <= ELTS_ED_RUN;
              edit_go_o <= 1'b1;
              pend_r    <= 1'b0;
            end
          end
        end
        ELTS_ED_WAIT: begin
          if (!lock) begin
            ed_r      <= ELTS_ED_RUN;
            edit_go_o <= 1'b1;
          end
        end
        ELTS_ED_RUN: begin
          // Keep one request that lands mid-edit; it starts from idle
          if (edit_i.req) begin
            pend_r <= 1'b1;
          end
          if (edit_i.done) begin
            ed_r <= ELTS_ED_IDLE;
          end else if (lock) begin
            ed_r <= ELTS_ED_WAIT;
          end
        end
        default: ed_r <= ELTS_ED_IDLE;
      endcase
    end
  end

  // Second request while waiting: discard and flag; set beats clear
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      err_r      <= 1'b0;
      edit_err_o <= 1'b0;
    end else begin
      edit_err_o <= refuse;
      if (refuse) begin
        err_r <= 1'b1;
      end else if (wr_acc && paddr_i == ELTS_OFF_EDIT_STAT &&
                   pwdata_i[ELTS_ERR_BIT]) begin
        err_r <= 1'b0;
      end
    end
  end

  // Trace configuration registers
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      src_r   <= ELTS_SRC_PERIOD;
      per_r   <= 8'h01;
      nw_r    <= 3'h0;
      dly_r   <= 13'h0000;
      rdidx_r <= '0;
    end else if (wr_acc) begin
      case (paddr_i)
        ELTS_OFF_TR_CFG: begin
          src_r <= pwdata_i[1:0];
          per_r <= pwdata_i[15:8];
          nw_r  <= (pwdata_i[18:16] > 3'h6) ? 3'h6 : pwdata_i[18:16];
        end
        ELTS_OFF_TR_DELAY: dly_r   <= pwdata_i[12:0];
        ELTS_OFF_TR_RADDR: rdidx_r <= pwdata_i[AW-1:0];
        default: ;
      endcase
    end
  end

  // Start and trigger bits; the start bit is for the programming device
  // only, the block trusts software never to set it from user logic
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      start_r <= 1'b0;
      trig_r  <= 1'b0;
    end else if (wr_acc && paddr_i == ELTS_OFF_TR_CTRL) begin
      start_r <= pwdata_i[ELTS_TR_START_BIT];
      trig_r  <= pwdata_i[ELTS_TR_TRIG_BIT];
    end else if (tr_r == ELTS_TR_DONE) begin
      start_r <= 1'b0;
    end
  end

  // Period timer: 10 ms steps, per_r steps per sample
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || tr_r == ELTS_TR_IDLE) begin
      tick_r  <= '0;
      stepc_r <= 8'h01;
    end else if (tick_r == 32'(STEP_CYC - 1)) begin
      tick_r  <= '0;
      stepc_r <= (stepc_r >= per_r) ? 8'h01 : stepc_r + 8'h01;
    end else begin
      tick_r <= tick_r + 32'h1;
    end
  end

  // Sample strobe per source; zero period gives no samples in period and cycle modes
  always_comb begin
    case (src_r)
      ELTS_SRC_PERIOD: strobe = per_r != 8'h00 && tick_r == 32'(STEP_CYC - 1)
                                && stepc_r >= per_r;
      ELTS_SRC_CYCLE:  strobe = per_r != 8'h00 && scan_end_i;
      ELTS_SRC_INSTR:  strobe = trace_sample_instruction_i;
      default:         strobe = 1'b0;
    endcase
  end

  // Instruction mode samples only after the trigger
  assign hit = strobe && (src_r != ELTS_SRC_INSTR || trig_r);

  // Trace sequencer: circular pre-trigger, then fill
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      tr_r  <= ELTS_TR_IDLE;
      wp_r  <= '0;
      cnt_r <= '0;
    end else begin
      case (tr_r)
        ELTS_TR_IDLE: begin
          if (start_r) begin
            tr_r  <= ELTS_TR_PRE;
            wp_r  <= '0;
            cnt_r <= '0;
          end
        end
        ELTS_TR_PRE: begin
          if (hit) begin
            wp_r <= (wp_r == depth_of(nw_r)) ? '0 : wp_r + 1'b1;
          end
          if (trig_r) begin
            tr_r <= ELTS_TR_POST;
            // Rows still to store: a negative delay leaves |delay| older
            // rows in the ring, a positive one lets the ring roll past the
            // first rows; one extra bit keeps depth plus 2000 from wrapping
            cnt_r <= CW'(depth_of(nw_r)) + dly_r + CW'(1);
          end
        end
        ELTS_TR_POST: begin
          if (hit) begin
            wp_r  <= (wp_r == depth_of(nw_r)) ? '0 : wp_r + 1'b1;
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == '0 || cnt_r == CW'(1)) begin
              tr_r <= ELTS_TR_DONE;
            end
          end
          if (!start_r) begin
            tr_r <= ELTS_TR_DONE;
          end
        end
        ELTS_TR_DONE: begin
          if (!start_r && !trig_r) begin
            tr_r <= ELTS_TR_IDLE;
          end
        end
        default: tr_r <= ELTS_TR_IDLE;
      endcase
    end
  end

  // Trace memory write, bits and all six words
  always_ff @(posedge mclk_i) begin
    if ((tr_r == ELTS_TR_PRE || tr_r == ELTS_TR_POST) && hit) begin
      mem[wp_r] <= {tr_words_i, tr_bits_i};
    end
    rd_r <= mem[rdidx_r];
  end

  // Read mux
  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr_i)
      ELTS_OFF_EDIT_CTRL: begin
        rdata[ELTS_VAL_LSB +: 8] = val_r;
        rdata[ELTS_DIS_BIT]      = dis_r;
      end
      ELTS_OFF_EDIT_STAT: begin
        rdata[ELTS_ERR_BIT]  = err_r;
        rdata[ELTS_WAIT_BIT] = ed_r == ELTS_ED_WAIT;
        rdata[ELTS_PROC_BIT] = ed_r == ELTS_ED_RUN;
      end
      ELTS_OFF_OUT_CTRL: rdata[ELTS_OUTOFF_BIT] = outoff_r;
      ELTS_OFF_TR_CFG:   rdata = {13'h0, nw_r, per_r, 6'h0, src_r};
      ELTS_OFF_TR_DELAY: rdata = {{19{dly_r[12]}}, dly_r};
      ELTS_OFF_TR_CTRL: begin
        rdata[ELTS_TR_START_BIT] = start_r;
        rdata[ELTS_TR_TRIG_BIT]  = trig_r;
      end
      // Pointer in 27:16, remaining rows in 14:2, state in 1:0
      ELTS_OFF_TR_STAT:  rdata = {4'h0, wp_r, 1'b0, cnt_r, tr_r};
      ELTS_OFF_TR_RADDR: rdata = {20'h0, rdidx_r};
      ELTS_OFF_TR_RDATA: rdata = rd_r[31:0];
      default: ;
    endcase
  end

  // APB answer: zero wait state, error on unmapped offsets
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & (paddr_i > ELTS_OFF_TR_RDATA |
                   paddr_i[1:0] != 2'b00);
      prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? rdata : 32'h0000_0000;
    end
  end

  logic unused_rd;
  assign unused_rd = rd_acc;

endmodule : elts_core
`default_nettype wire

/* sim/elts_progdev.sv */
// Purpose: Programming device model that raises edit requests
// Assumes: Request and done are one-cycle pulses
// Notes:   Done latency is set per edit by the bench
`timescale 1ns/1ps
`default_nettype none
module elts_progdev
  import elts_pkg::*;
(
  input  wire logic            mclk_i,
  input  wire logic            resetn_i,
  input  wire logic            req_i,   // Bench asks for an edit
  input  wire logic [7:0]      lat_i,   // Edit length in cycles
  input  wire logic            go_i,    // Edit started by the device
  output var elts_pkg::elts_edit_t edit_o
);
  logic [7:0] cnt_r; // Cycles left until done

  // Relay request, time the edit from each start
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      edit_o <= '0;
      cnt_r  <= 8'h00;
    end else begin
      edit_o.req  <= req_i;
      edit_o.done <= (cnt_r == 8'h01);
      // A restart after suspension reloads the full length
      if (go_i) begin
        cnt_r <= lat_i;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : elts_progdev
`default_nettype wire

/* sim/elts_core_props.sv */
// Purpose: Port-level checks of the lockout block
// Assumes: One clock, sync active-low reset
// Notes:   Output gating allows one cycle of lag
`timescale 1ns/1ps
`default_nettype none
module elts_core_props
  import elts_pkg::*;
#(
  parameter int OUT_W = 32
) (
  input  wire logic                 mclk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          prdata_o,
  input  wire logic                 pready_o,
  input  wire logic                 pslverr_o,
  input  wire elts_pkg::elts_edit_t edit_i,
  input  wire logic                 edit_go_o,
  input  wire logic                 edit_err_o,
  input  wire logic [OUT_W-1:0]     out_img_i,
  input  wire logic [OUT_W-1:0]     out_pins_o,
  input  wire logic                 output_inhibit_indicator_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // Setup phase, and one aimed at no register
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence bad_s;
    setup_s ##0 (paddr_i > 8'h20 || paddr_i[1:0] != 2'b00);
  endsequence

  apb_answer_a: assert property (setup_s |=> pready_o && penable_i)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  bad_addr_a: assert property (bad_s |=> pslverr_o)
    else $error("bad address accepted");
  bad_read_a: assert property (bad_s ##0 !pwrite_i |=> prdata_o == 32'h0)
    else $error("bad read data");
  go_pulse_a: assert property (edit_go_o |=> !edit_go_o)
    else $error("start held");
  err_cause_a: assert property (edit_err_o |-> $past(edit_i.req) && !edit_go_o)
    else $error("error without request");
  outs_off_a: assert property (
    output_inhibit_indicator_o && $past(output_inhibit_indicator_o) |-> out_pins_o == '0)
    else $error("outputs on while inhibited");
  outs_pass_a: assert property (!output_inhibit_indicator_o &&
    !$past(output_inhibit_indicator_o) && !$past(output_inhibit_indicator_o, 2) &&
    $past(resetn_i) && $past(resetn_i, 2) |-> out_pins_o == $past(out_img_i))
    else $error("outputs not passed");
endmodule : elts_core_props

bind elts_core elts_core_props #(.OUT_W(OUT_W)) u_props (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .edit_i(edit_i), .edit_go_o(edit_go_o),
  .edit_err_o(edit_err_o), .out_img_i(out_img_i), .out_pins_o(out_pins_o),
  .output_inhibit_indicator_o(output_inhibit_indicator_o));
`default_nettype wire

/* sim/tb_edit_lockout_and_data_trace.sv */
// Purpose: Self-checking bench for the lockout block
// Assumes: APB answers in the access cycle
// Notes:   Trace rows checked in instruction mode with hand-timed pulses
`timescale 1ns/1ps
`default_nettype none
module tb_edit_lockout_and_data_trace;
  import elts_pkg::*;
  localparam logic [31:0] WM = 32'h0000_0c01; // Wait, busy, error flags
  localparam logic [31:0] LK = 32'h0000_025a; // Key plus disable bit
  localparam logic [31:0] TM = 32'h0fff_0003; // Trace pointer and state
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
  logic        req = 0, nv = 0, scan = 0, trace_sample_instruction = 0, e, quiet = 0, tsp = 0;
  logic [31:0] tw;
  logic        prdy, perr, go, err, ind;
  logic [7:0]  paddr = 0, lat = 8'h03, v;
  logic [31:0] pwd = 0, img = 0, prd, prd_o, pins, k;
  logic [30:0] bits = 0;
  logic [95:0] wds = 0;
  elts_edit_t  ed;
  int          n_mismatch = 0, n_tests = 0, n_go = 0, n_err = 0, cyc = 0, g, f, n;

  always #2.5 clk = ~clk;

  elts_core #(.STEP_CYC(10), .OUT_W(32)) dut_u (
    .mclk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd_o), .pready_o(prdy),
    .pslverr_o(perr), .edit_i(ed), .edit_go_o(go), .edit_err_o(err),
    .outoff_nv_i(nv), .out_img_i(img), .out_pins_o(pins),
    .output_inhibit_indicator_o(ind), .scan_end_i(scan),
    .trace_sample_instruction_i(trace_sample_instruction | tsp), .tr_bits_i(bits), .tr_words_i(wds));

  elts_progdev pd_u (.mclk_i(clk), .resetn_i(rstn), .req_i(req), .lat_i(lat),
    .go_i(go), .edit_o(ed));

  // Pulse counters, trace traffic, hang guard
  always @(posedge clk) begin
    cyc++;
    if (go === 1'b1) n_go++;
    if (err === 1'b1) n_err++;
    bits <= 31'($urandom);
    wds  <= {3{$urandom}};
    scan <= ($urandom % 8 == 0);
    trace_sample_instruction <= !quiet && ($urandom % 16 == 0);
    if (cyc == 6000) begin
      n_mismatch++;
      close_out();
    end
  end

  task close_out;
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    n_tests++;
    if (s !== x) begin
      $display("MISMATCH %s exp %h got %h", nm, x, s);
      n_mismatch++;
    end
  endtask : chk

  // One APB transfer, held until ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel  <= 1'b1;
    pwr   <= w;
    paddr <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    prd = prd_o;
    e   = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask : apb

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, prd & m);
  endtask : rdc

  // Rows stored after the trigger for a word count and delay
  function automatic int post_rows(input int nw, input int d);
    return ELTS_MEM_WORDS / (nw + 1) + d;
  endfunction : post_rows

  // Sample instruction pulses; keep the low word of the last row taken
  task tpulse(input int cnt);
    repeat (cnt) begin
      tsp <= 1'b1;
      @(posedge clk);
      tw = {wds[0], bits};
      tsp <= 1'b0;
      @(posedge clk);
    end
  endtask : tpulse

  // Edit request, then let the answer land
  task edreq;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : edreq

  initial begin
    k = $urandom(82840);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rdc("edit_ctrl", ELTS_OFF_EDIT_CTRL, 32'h0000_02ff, 32'h0);
    rdc("edit_stat", ELTS_OFF_EDIT_STAT, WM, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, prd);
    // Disable bit without the key is ignored
    for (int i = 0; i < 4; i++) begin
      k = $urandom;
      v = (i == 0) ? 8'h5b : k[7:0];
      if (v == ELTS_VALID_KEY) v = 8'h00;
      apb(1'b1, ELTS_OFF_EDIT_CTRL, 32'h0000_0200 | 32'(v));
      g = n_go;
      edreq();
      chk("go_unkeyed", g + 1, n_go);
    end
    // Locked request waits, second one is refused
    lat <= 8'h28;
    apb(1'b1, ELTS_OFF_EDIT_CTRL, LK);
    g = n_go;
    edreq();
    chk("go_locked", g, n_go);
    rdc("wait_set", ELTS_OFF_EDIT_STAT, WM, 32'h0000_0400);
    f = n_err;
    edreq();
    chk("err_pulse", f + 1, n_err);
    rdc("err_bit", ELTS_OFF_EDIT_STAT, WM, 32'h0000_0401);
    apb(1'b1, ELTS_OFF_EDIT_STAT, 32'h1);
    rdc("err_clr", ELTS_OFF_EDIT_STAT, WM, 32'h0000_0400);
    apb(1'b1, ELTS_OFF_EDIT_CTRL, 32'h0000_005a);
    repeat (4) @(posedge clk);
    chk("go_release", g + 1, n_go);
    rdc("proc_set", ELTS_OFF_EDIT_STAT, WM, 32'h0000_0800);
    repeat (60) @(posedge clk);
    rdc("proc_clr", ELTS_OFF_EDIT_STAT, WM, 32'h0);
    chk("one_go", g + 1, n_go);
    // Request during a running edit is held, then served
    g = n_go;
    edreq();
    edreq();
    repeat (90) @(posedge clk);
    chk("go_held", g + 2, n_go);
    // Lock taken while an edit runs
    lat <= 8'h50;
    edreq();
    apb(1'b1, ELTS_OFF_EDIT_CTRL, LK);
    rdc("wait_on_lock", ELTS_OFF_EDIT_STAT, 32'h0000_0400, 32'h0000_0400);
    apb(1'b1, ELTS_OFF_EDIT_CTRL, 32'h0000_005a);
    repeat (120) @(posedge clk);
    rdc("wait_gone", ELTS_OFF_EDIT_STAT, 32'h0000_0400, 32'h0);
    // Output-off gating
    img <= $urandom;
    apb(1'b1, ELTS_OFF_OUT_CTRL, 32'h0000_8000);
    repeat (3) @(posedge clk);
    chk("ind_on", 32'h1, {31'h0, ind});
    chk("pins_off", 32'h0, pins);
    apb(1'b1, ELTS_OFF_OUT_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk("pins_pass", img, pins);
    // Stored output-off survives a power cycle
    nv   <= 1'b1;
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ind_kept", 32'h1, {31'h0, ind});
    rdc("off_kept", ELTS_OFF_OUT_CTRL, 32'h0000_8000, 32'h0000_8000);
    // Trace traffic: per-cycle, then instruction driven
    apb(1'b1, ELTS_OFF_TR_CFG, 32'h0000_0101);
    apb(1'b1, ELTS_OFF_TR_DELAY, 32'h0000_1ffb);
    apb(1'b1, ELTS_OFF_TR_CTRL, 32'h0000_8000);
    apb(1'b1, ELTS_OFF_TR_CTRL, 32'h0000_c000);
    repeat (100) @(posedge clk);
    apb(1'b1, ELTS_OFF_TR_CFG, 32'h0000_0002);
    repeat (100) @(posedge clk);
    // Instruction-driven trace, six words, delay -499, hand pulses only
    quiet <= 1'b1;
    apb(1'b1, ELTS_OFF_TR_CTRL, 32'h0);
    apb(1'b1, ELTS_OFF_TR_CFG, 32'h0006_0002);
    apb(1'b1, ELTS_OFF_TR_DELAY, 32'h0000_1e0d);
    apb(1'b1, ELTS_OFF_TR_CTRL, 32'h0000_8000);
    tpulse(5);
    rdc("tr_pretrig", ELTS_OFF_TR_STAT, TM, 32'h0000_0001);
    apb(1'b1, ELTS_OFF_TR_CTRL, 32'h0000_c000);
    n = post_rows(6, -499);
    tpulse(n - 1);
    rdc("tr_post", ELTS_OFF_TR_STAT, TM, {4'h0, 12'(n - 1), 14'h0, 2'b10});
    tpulse(1);
    rdc("tr_done", ELTS_OFF_TR_STAT, TM, {4'h0, 12'(n), 14'h0, 2'b11});
    rdc("tr_stop", ELTS_OFF_TR_CTRL, 32'h0000_8000, 32'h0);
    apb(1'b1, ELTS_OFF_TR_RADDR, 32'(n - 1));
    rdc("tr_row", ELTS_OFF_TR_RDATA, 32'hffff_ffff, tw);
    close_out();
  end
endmodule : tb_edit_lockout_and_data_trace
`default_nettype wire
